/* bench/io_port_sva.sv */
// assertion checker for the six-bit i/o port block
`timescale 1ns/1ps
`default_nettype none
module io_port_sva #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  sleep_i,
  input wire logic [WIDTH-1:0]      alt_func_b_i,
  input wire io_port_pkg::cpu_req_s req_i,
  input wire io_port_pkg::w_load_s  wload_i,
  input wire logic [WIDTH-1:0]      pin_b_i,
  input wire logic                  cyc_start_o,
  input wire logic                  cyc_end_o,
  input wire logic [7:0]            rdata_o,
  input wire logic                  rdata_valid_o,
  input wire logic [WIDTH-1:0]      pin_b_oe_n_o,
  input wire logic [WIDTH-1:0]      pin_c_oe_n_o,
  input wire logic [WIDTH-1:0]      pullup_b_o,
  input wire logic                  pin_change_wake_flag_o,
  input wire logic                  wake_request_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cycle_period: assert property (
    cyc_start_o |=> !cyc_start_o [*3] ##1 cyc_start_o)
    else $error("cycle start period wrong");
  a_end_follows: assert property (
    cyc_start_o |-> ##3 cyc_end_o)
    else $error("cycle end not three clocks after start");
  a_input_only: assert property (pin_b_oe_n_o[3])
    else $error("input only pin driven");
  a_high_bits_zero: assert property (
    rdata_valid_o |-> rdata_o[7:6] == 2'h0)
    else $error("upper read bits not zero");
  a_read_pins: assert property (
    rdata_valid_o && $past(req_i.valid && !req_i.wr && !req_i.bit_set
      && !req_i.bit_clr && req_i.addr == io_port_pkg::OFS_PORT_B_DATA)
    |-> rdata_o[5:0] == $past(pin_b_i & ~alt_func_b_i))
    else $error("port read differs from pins");
  a_pullup_pins: assert property (
    (pullup_b_o & ~io_port_pkg::WAKE_PIN_MASK) == 6'h00)
    else $error("pull-up on unsupported pin");
  a_reset_dirs: assert property (
    $fell(rst_i) |-> pin_b_oe_n_o == 6'h3F && pin_c_oe_n_o == 6'h3F)
    else $error("pins not inputs after reset");
  a_flag_stable: assert property (
    !$past(rst_i) |-> $stable(pin_change_wake_flag_o))
    else $error("wake flag moved outside reset");
  a_wake_asleep: assert property (
    $rose(wake_request_o) |-> $past(sleep_i))
    else $error("wake request while awake");
  a_dir_to_oe: assert property (
    cyc_start_o && $past(wload_i.dir_load
      && wload_i.port_addr == io_port_pkg::OFS_PORT_B_DATA)
    |-> ##4 pin_b_oe_n_o == ($past(wload_i.w[5:0], 5) | 6'h08))
    else $error("direction load not on drivers");

  c_read: cover property (rdata_valid_o);
  c_wake: cover property ($rose(wake_request_o));
  c_end: cover property (cyc_end_o);
endmodule : io_port_sva
`default_nettype wire

/* bench/pin_env.sv */
// outside circuitry model on one six-pin port
`timescale 1ns/1ps
`default_nettype none
module pin_env (
  input  wire logic       clk_i,
  input  wire logic [5:0] drv_i,
  input  wire logic [5:0] oe_n_i,
  input  wire logic [5:0] pu_i,
  input  wire logic [5:0] ext_i,
  input  wire logic [5:0] ext_en_i,
  output var  logic [5:0] pin_o
);
  logic [5:0] flt_q = 6'h00;
  // undriven lines wander so a stale level never passes
  // plain process: the initial value keeps the first level known
  always @(posedge clk_i) begin
    flt_q <= ~flt_q;
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_o[i] = !oe_n_i[i] ? drv_i[i] : ext_en_i[i] ? ext_i[i] :
                 pu_i[i] ? 1'b1 : flt_q[i];
    end
  end
endmodule : pin_env
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the six-bit i/o port block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'h0, rst_i = 1'h1, wake_reset_i = 1'h0;
  logic sleep_i = 1'h0, master_clear_input_enable_i = 1'h0;
  logic [5:0] alt_func_b_i = 6'h00, alt_func_c_i = 6'h00;
  logic [5:0] pin_b_i, pin_c_i, pin_b_o, pin_b_oe_n_o, pullup_b_o;
  logic [5:0] pin_c_o, pin_c_oe_n_o;
  logic [5:0] ext_b = 6'h00, ext_c = 6'h00, en_b = 6'h00, en_c = 6'h00;
  io_port_pkg::cpu_req_s req_i = '0;
  io_port_pkg::w_load_s  wload_i = '0;
  logic cyc_start_o, cyc_end_o, rdata_valid_o;
  logic pin_change_wake_flag_o, wake_request_o;
  logic [7:0] rdata_o;
  int n_errors = 0, checks = 0, cyc = 0;

  six_bit_io_port uut (.*);
  pin_env env_b (.clk_i, .drv_i(pin_b_o), .oe_n_i(pin_b_oe_n_o),
    .pu_i(pullup_b_o), .ext_i(ext_b), .ext_en_i(en_b), .pin_o(pin_b_i));
  pin_env env_c (.clk_i, .drv_i(pin_c_o), .oe_n_i(pin_c_oe_n_o),
    .pu_i(6'h00), .ext_i(ext_c), .ext_en_i(en_c), .pin_o(pin_c_i));

  initial forever #2.5 clk_i = ~clk_i;

  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  function automatic io_port_pkg::cpu_req_s rq(input logic [2:0] k,
    input logic [2:0] s, input logic [7:0] a, input logic [7:0] d);
    rq = {1'b1, k, s, a, d};
  endfunction : rq

  // present after a start pulse, hold through the take edge
  task automatic op(input io_port_pkg::cpu_req_s r,
                    input io_port_pkg::w_load_s w);
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      #1;
      k++;
    end while (cyc_start_o !== 1'b1 && k < 9);
    req_i = r;
    wload_i = w;
    repeat (4) @(posedge clk_i);
    #1;
    req_i = '0;
    wload_i = '0;
  endtask : op

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    op(rq(3'h0, 3'h0, a, 8'h00), '0);
    cmp(rdata_o, e);
    cmp({7'h00, rdata_valid_o}, 8'h01);
  endtask : rd

  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic reset(input logic wk);
    rst_i = 1'h1;
    wake_reset_i = wk;
    repeat (12) @(posedge clk_i);
    #1;
    rst_i = 1'h0;
    wake_reset_i = 1'h0;
    cmp({2'h0, pin_b_oe_n_o}, 8'h3F);
    cmp({2'h0, pin_c_oe_n_o}, 8'h3F);
    cmp({2'h0, pullup_b_o}, 8'h00);
    cmp({7'h00, pin_change_wake_flag_o}, {7'h00, wk});
  endtask : reset

  task automatic t_read();
    ext_b = 6'h2D;
    en_b = 6'h3F;
    alt_func_b_i = 6'h05;
    rd(8'h06, 8'h28);
    alt_func_b_i = 6'h00;
    rd(8'h06, 8'h2D);
    ext_c = 6'h3F;
    en_c = 6'h3F;
    alt_func_c_i = 6'h21;
    rd(8'h07, 8'h1E);
    rd(8'h05, 8'h00);
    rd(8'h03, 8'h00);
  endtask : t_read

  task automatic t_drive();
    op(rq(3'h4, 3'h0, 8'h06, 8'hC5), '0);
    en_b = 6'h08;
    op('0, {1'b1, 1'b0, 8'h06, 8'h00});
    settle();
    cmp({2'h0, pin_b_oe_n_o}, 8'h08);
    cmp({2'h0, pin_b_o}, 8'h05);
    rd(8'h06, 8'h0D);
  endtask : t_drive

  task automatic bitop(input logic [2:0] k, input logic [2:0] s,
                       input logic [7:0] e);
    op(rq(k, s, 8'h06, 8'h00), '0);
    repeat (3) @(posedge clk_i);
    #1;
    cmp({2'h0, pin_b_o}, e);
  endtask : bitop

  task automatic t_rmw();
    op('0, {1'b1, 1'b0, 8'h06, 8'h3F});
    ext_b = 6'h12;
    settle();
    en_b = 6'h3F;
    bitop(3'h2, 3'h0, 8'h13);
    bitop(3'h1, 3'h4, 8'h02);
    bitop(3'h2, 3'h6, 8'h12);
  endtask : t_rmw

  task automatic t_option();
    master_clear_input_enable_i = 1'h1;
    settle();
    cmp({2'h0, pullup_b_o}, 8'h08);
    master_clear_input_enable_i = 1'h0;
    en_c = 6'h20;
    op('0, {1'b1, 1'b0, 8'h07, 8'h00});
    settle();
    cmp({2'h0, pin_c_oe_n_o}, 8'h20);
    en_c = 6'h00;
    op('0, {1'b0, 1'b1, 8'h00, 8'h00});
    settle();
    cmp({2'h0, pin_c_oe_n_o}, 8'h00);
    cmp({2'h0, pullup_b_o}, 8'h1B);
    op(rq(3'h4, 3'h0, 8'h07, 8'hEA), '0);
    settle();
    cmp({2'h0, pin_c_o}, 8'h2A);
  endtask : t_option

  task automatic wk_chk(input logic e);
    settle();
    cmp({7'h00, wake_request_o}, {7'h00, e});
  endtask : wk_chk

  task automatic t_wake();
    rd(8'h06, 8'h12);
    sleep_i = 1'h1;
    ext_b = 6'h16;
    wk_chk(1'h0);
    master_clear_input_enable_i = 1'h1;
    ext_b = 6'h1E;
    wk_chk(1'h0);
    ext_b = 6'h16;
    master_clear_input_enable_i = 1'h0;
    wk_chk(1'h0);
    ext_b = 6'h17;
    wk_chk(1'h1);
    sleep_i = 1'h0;
    reset(1'h1);
    reset(1'h0);
  endtask : t_wake

  initial begin
    reset(1'h0);
    t_read();
    t_drive();
    t_rmw();
    t_option();
    t_wake();
    give_verdict();
  end
endmodule : tb_top

bind six_bit_io_port io_port_sva #(.WIDTH(WIDTH)) u_sva (.*);
`default_nettype wire

/* hdl/cycle_phase_gen.sv */
// instruction cycle phase divider: start and end enables
`timescale 1ns/1ps
`default_nettype none
module cycle_phase_gen (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output var  logic start_o,
  output var  logic end_o
);
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_e;

  phase_e phase_q;
  phase_e phase_d;

  always_comb begin
    case (phase_q)
      PH_Q1:   phase_d = PH_Q2;
      PH_Q2:   phase_d = PH_Q3;
      PH_Q3:   phase_d = PH_Q4;
      PH_Q4:   phase_d = PH_Q1;
      default: phase_d = PH_Q1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= PH_Q4;
    end else begin
      phase_q <= phase_d;
    end
  end

  // pulses registered so they align with the phase they name
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_o <= 1'b0;
      end_o   <= 1'b0;
    end else begin
      start_o <= (phase_d == PH_Q1);
      end_o   <= (phase_d == PH_Q4);
    end
  end
endmodule : cycle_phase_gen
`default_nettype wire

/* hdl/io_port_pkg.sv */
// constants, layouts and carriers for the six-bit i/o port block
package io_port_pkg;

  localparam int unsigned PORT_WIDTH = 6;

  // register file offsets
  localparam logic [7:0] OFS_CPU_STATUS  = 8'h03;
  localparam logic [7:0] OFS_PORT_B_DATA = 8'h06;
  localparam logic [7:0] OFS_PORT_C_DATA = 8'h07;

  // reset values
  localparam logic [5:0] DIRECTION_RESET = 6'h3F;
  localparam logic [7:0] OPTION_RESET    = 8'hFF;

  // option register fields
  localparam int unsigned OPT_WAKE_EN_N_BIT  = 7;
  localparam int unsigned OPT_PULLUP_EN_N_BIT = 6;
  localparam int unsigned OPT_TIMER_SRC_BIT  = 5;

  // status register wake flag position
  localparam int unsigned STATUS_WAKE_BIT = 7;

  // port b pins carrying pull-up and wake-on-change
  localparam logic [5:0] WAKE_PIN_MASK  = 6'h1B;
  localparam int unsigned INPUT_ONLY_BIT = 3;
  // port c pin shared with the timer clock input
  localparam int unsigned TIMER_PIN_BIT  = 5;

  // instruction cycle = four clocks; last phase
  localparam logic [1:0] PHASE_LAST = 2'h3;

  typedef struct packed {
    logic       valid;
    logic       wr;
    logic       bit_set;
    logic       bit_clr;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_req_s;

  typedef struct packed {
    logic       dir_load;
    logic       opt_load;
    logic [7:0] port_addr;
    logic [7:0] w;
  } w_load_s;

endpackage : io_port_pkg

/* hdl/pin_bank.sv */
// one port: output latches, write-only direction bits, pin drivers
`timescale 1ns/1ps
`default_nettype none
module pin_bank #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             latch_we_i,
  input  wire logic [WIDTH-1:0] latch_d_i,
  input  wire logic             dir_we_i,
  input  wire logic [WIDTH-1:0] dir_d_i,
  input  wire logic [WIDTH-1:0] force_in_i,
  output var  logic [WIDTH-1:0] pin_o,
  output var  logic [WIDTH-1:0] pin_oe_n_o
);
  logic [WIDTH-1:0] dir_q;

  // latch holds until rewritten; reset leaves it untouched like silicon
  always_ff @(posedge clk_i) begin
    if (latch_we_i) begin
      pin_o <= latch_d_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_q <= WIDTH'(io_port_pkg::DIRECTION_RESET);
    end else if (dir_we_i) begin
      dir_q <= dir_d_i;
    end
  end

  // one means high impedance; forced bits never drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_oe_n_o <= '1;
    end else begin
      pin_oe_n_o <= dir_q | force_in_i;
    end
  end
endmodule : pin_bank
`default_nettype wire

/* hdl/six_bit_io_port.sv */
// general purpose six-bit i/o ports b and c with wake-on-change
// Function
// - port read returns live pin levels, never the output latch
// - every reset sets all direction bits, pins become inputs
// - only six data bits exist; bits seven and six read zero
// - port b bit three is input only, driver never enabled
// - pins given to alternate functions read as zero
// - pull-up and wake on b bits 0,1,3,4, each under its own option enable bit (six, seven)
// - master clear mode: bit three pull-up on, no wake from it
// - direction load instruction copies w into the port direction
// - direction one floats the pin, zero drives the latch value
// - option register may govern timer clock pin direction
// - timer clock source select set forces timer pin to input
// - direction registers are write-only, no read path
// - inputs are not latched; output latches hold until written
// - bit set and clear read pins, modify, write all latches
// - writes land at cycle end, reads sample at cycle start
// - status wake flag set on wake reset, cleared otherwise
`timescale 1ns/1ps
`default_nettype none
module six_bit_io_port #(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wake_reset_i,
  input  wire logic                  sleep_i,
  input  wire logic                  master_clear_input_enable_i,
  input  wire logic [WIDTH-1:0]      alt_func_b_i,
  input  wire logic [WIDTH-1:0]      alt_func_c_i,
  input  wire io_port_pkg::cpu_req_s req_i,
  input  wire io_port_pkg::w_load_s  wload_i,
  input  wire logic [WIDTH-1:0]      pin_b_i,
  input  wire logic [WIDTH-1:0]      pin_c_i,
  output var  logic                  cyc_start_o,
  output var  logic                  cyc_end_o,
  output var  logic [7:0]            rdata_o,
  output var  logic                  rdata_valid_o,
  output var  logic [WIDTH-1:0]      pin_b_o,
  output var  logic [WIDTH-1:0]      pin_b_oe_n_o,
  output var  logic [WIDTH-1:0]      pullup_b_o,
  output var  logic [WIDTH-1:0]      pin_c_o,
  output var  logic [WIDTH-1:0]      pin_c_oe_n_o,
  output var  logic                  pin_change_wake_flag_o,
  output var  logic                  wake_request_o
);
  logic                  cyc_start;
  logic                  cyc_end;
  io_port_pkg::cpu_req_s req_q;
  io_port_pkg::w_load_s  wload_q;
  logic [7:0]            option_q;
  logic [WIDTH-1:0]      rmw_base_q;
  logic [WIDTH-1:0]      last_read_b_q;
  logic [WIDTH-1:0]      read_b;
  logic [WIDTH-1:0]      read_c;
  logic [WIDTH-1:0]      bit_mask;
  logic [WIDTH-1:0]      latch_d;
  logic                  latch_b_we;
  logic                  latch_c_we;
  logic                  dir_b_we;
  logic                  dir_c_we;
  logic [WIDTH-1:0]      force_b;
  logic [WIDTH-1:0]      force_c;
  logic [WIDTH-1:0]      wake_mask;
  logic                  wake_en;
  logic                  pullup_en;
  logic                  req_writes;

  cycle_phase_gen u_phase (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_o (cyc_start),
    .end_o   (cyc_end)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_start_o <= 1'b0;
      cyc_end_o   <= 1'b0;
    end else begin
      cyc_start_o <= cyc_start;
      cyc_end_o   <= cyc_end;
    end
  end

  assign read_b = pin_b_i & ~alt_func_b_i;
  assign read_c = pin_c_i & ~alt_func_c_i;

  assign wake_en   = ~option_q[io_port_pkg::OPT_WAKE_EN_N_BIT];
  assign pullup_en = ~option_q[io_port_pkg::OPT_PULLUP_EN_N_BIT];

  // request taken at cycle start, carried to cycle end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q   <= '0;
      wload_q <= '0;
    end else if (cyc_start) begin
      req_q   <= req_i;
      wload_q <= wload_i;
    end else if (cyc_end) begin
      req_q   <= '0;
      wload_q <= '0;
    end
  end

  // pin level only copied for this one instruction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o       <= 8'h00;
      rdata_valid_o <= 1'b0;
      rmw_base_q    <= '0;
    end else begin
      rdata_valid_o <= cyc_start & req_i.valid;
      if (cyc_start && req_i.valid) begin
        case (req_i.addr)
          io_port_pkg::OFS_PORT_B_DATA: begin
            rdata_o    <= {2'b00, read_b};
            rmw_base_q <= read_b;
          end
          io_port_pkg::OFS_PORT_C_DATA: begin
            rdata_o    <= {2'b00, read_c};
            rmw_base_q <= read_c;
          end
          io_port_pkg::OFS_CPU_STATUS: begin
            rdata_o    <= {pin_change_wake_flag_o, 7'h00};
            rmw_base_q <= '0;
          end
          default: begin
            rdata_o    <= 8'h00;
            rmw_base_q <= '0;
          end
        endcase
      end
    end
  end

  // modify the sampled pins, rewrite every latch
  assign bit_mask   = WIDTH'(6'h01 << req_q.bit_sel);
  assign req_writes = req_q.valid & (req_q.wr | req_q.bit_set
                                     | req_q.bit_clr);
  always_comb begin
    if (req_q.wr) begin
      latch_d = req_q.wdata[WIDTH-1:0];
    end else if (req_q.bit_set) begin
      latch_d = rmw_base_q | bit_mask;
    end else begin
      latch_d = rmw_base_q & ~bit_mask;
    end
  end

  assign latch_b_we = cyc_end & req_writes
                      & (req_q.addr == io_port_pkg::OFS_PORT_B_DATA);
  assign latch_c_we = cyc_end & req_writes
                      & (req_q.addr == io_port_pkg::OFS_PORT_C_DATA);

  // no read path exists for these
  assign dir_b_we = cyc_end & wload_q.dir_load
                    & (wload_q.port_addr == io_port_pkg::OFS_PORT_B_DATA);
  assign dir_c_we = cyc_end & wload_q.dir_load
                    & (wload_q.port_addr == io_port_pkg::OFS_PORT_C_DATA);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      option_q <= io_port_pkg::OPTION_RESET;
    end else if (cyc_end && wload_q.opt_load) begin
      option_q <= wload_q.w;
    end
  end

  always_comb begin
    force_b = '0;
    force_b[io_port_pkg::INPUT_ONLY_BIT] = 1'b1;
  end

  always_comb begin
    force_c = '0;
    force_c[io_port_pkg::TIMER_PIN_BIT] =
      option_q[io_port_pkg::OPT_TIMER_SRC_BIT];
  end

  // direction reset and drive select inside each bank
  pin_bank #(.WIDTH(WIDTH)) u_bank_b (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .latch_we_i (latch_b_we),
    .latch_d_i  (latch_d),
    .dir_we_i   (dir_b_we),
    .dir_d_i    (wload_q.w[WIDTH-1:0]),
    .force_in_i (force_b),
    .pin_o      (pin_b_o),
    .pin_oe_n_o (pin_b_oe_n_o)
  );

  pin_bank #(.WIDTH(WIDTH)) u_bank_c (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .latch_we_i (latch_c_we),
    .latch_d_i  (latch_d),
    .dir_we_i   (dir_c_we),
    .dir_d_i    (wload_q.w[WIDTH-1:0]),
    .force_in_i (force_c),
    .pin_o      (pin_c_o),
    .pin_oe_n_o (pin_c_oe_n_o)
  );

  // one common enable for the four pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pullup_b_o <= '0;
    end else begin
      pullup_b_o <= pullup_en ? WIDTH'(io_port_pkg::WAKE_PIN_MASK) : '0;
      if (master_clear_input_enable_i) begin
        pullup_b_o[io_port_pkg::INPUT_ONLY_BIT] <= 1'b1;
      end
    end
  end

  // master clear pin excluded from wake
  always_comb begin
    wake_mask = WIDTH'(io_port_pkg::WAKE_PIN_MASK);
    if (master_clear_input_enable_i) begin
      wake_mask[io_port_pkg::INPUT_ONLY_BIT] = 1'b0;
    end
  end

  // reference level from last port b read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_read_b_q <= '0;
    end else if (cyc_start && req_i.valid
                 && req_i.addr == io_port_pkg::OFS_PORT_B_DATA) begin
      last_read_b_q <= read_b;
    end
  end

  // mismatch while asleep requests a wake reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_request_o <= 1'b0;
    end else begin
      wake_request_o <= sleep_i & wake_en
                        & (|((read_b ^ last_read_b_q) & wake_mask));
    end
  end

  // wake flag follows the reset cause
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_change_wake_flag_o <= wake_reset_i;
    end
  end

endmodule : six_bit_io_port
`default_nettype wire
